//--- rtl/hsc_channel.sv
`timescale 1ns/100ps
// Behaviour
// RULE_01: unmasked interrupt sets flag; interrupt read clears
// RULE_02: fifteen consecutive ones set idle flag
// RULE_03: idle flag starts set, valid after data
// RULE_04: status shows next receive byte tag
// RULE_05: status encodes transmit queue fill level
// RULE_06: select bit picks underrun or frame abort
// RULE_07: cycle mode reloads byte count minus one
// RULE_08: checksum suppress skips checksum after end byte
// RULE_09: seven-bit mode matches seven bits, bit0 set
// RULE_10: software keeps reserved bits written zero
// RULE_11: receive clear shows empty, holds receiver
// RULE_12: transmit clear empties queue, clears on write
// RULE_13: empty fetch raises underrun, read clears
// RULE_14: end tag marks next write, then clears
// RULE_15: control two read/write, resets to zero
module hsc_channel (
  input  wire logic       clk,              // 20 MHz clock
  input  wire logic       reset_n,          // Async reset
  input  wire logic [7:0] bus_addr,         // Register address
  input  wire logic       bus_rd,           // Read strobe, one cycle
  input  wire logic       bus_wr,           // Write strobe, one cycle
  input  wire logic [7:0] bus_wdata,        // Write data
  output logic      [7:0] bus_rdata,        // Read data
  output logic            bus_rdata_oe,     // Drives data bus
  input  wire logic       hdlc_irq_event,   // Other unmasked irq raised
  input  wire logic       bit2_mask,        // Mask for irq bit 2
  output logic            int_bit2,         // Irq register bit 2
  input  wire logic       rx_frame_abort,   // Frame abort received
  input  wire logic       rx_bit_valid,     // Received bit strobe
  input  wire logic       rx_bit,           // Received bit
  input  wire logic [1:0] rx_next_tag,      // Next receive byte tag
  input  wire logic [1:0] rx_fill_code,     // Receive queue fill
  input  wire logic       rx_flag_seen,     // Flag received
  output logic            rx_hold,          // Receiver held off
  input  wire logic       rx_addr_valid,    // First address byte strobe
  input  wire logic [7:0] rx_addr_byte,     // First address byte
  input  wire logic [7:0] rx_addr_pattern,  // Programmed address
  output logic            addr_match,       // Address matched
  input  wire logic       packet_end_tag,   // End tag for next write
  input  wire logic       frame_abort_tag,  // Abort tag for next write
  output logic            tag_clear,        // Clears both tags
  input  wire logic [7:0] tx_status_level,  // Status fill level
  input  wire logic [7:0] tx_irq_level,     // Interrupt threshold
  input  wire logic       tx_fetch,         // Transmitter wants a byte
  output logic            tx_byte_valid,    // Fetched byte ready
  output logic      [7:0] tx_byte,          // Fetched byte
  output logic            tx_byte_end,      // Byte ends a packet
  output logic            tx_byte_abort,    // Byte aborts a packet
  output logic            tx_send_fcs,      // Append checksum after byte
  input  wire logic [7:0] byte_count_init,  // Loaded byte count
  input  wire logic       tx_count_reload,  // Reload byte counter
  output logic      [7:0] tx_count          // Transmit byte counter
);
  import hsc_pkg::*;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  logic [7:0] ctrl2_r, ctrl2_nxt;
  logic       irq_raised_r, idle_r, bit2_r;
  logic [3:0] ones_r;
  logic       rx_hold_r, addr_match_r;
  logic [7:0] wr_ptr_r, rd_ptr_r;
  logic       pop_r, fcs_ok_r;
  logic [7:0] tx_count_r, rdata_r;
  logic       rdata_oe_r;
  logic [TXQ_W-1:0] mem_q;

  // Address decode
  wire wr_ctrl2  = bus_wr & sel(bus_addr, ADDR_CTRL2);
  wire wr_txq    = bus_wr & sel(bus_addr, ADDR_TX_FIFO);
  wire rd_status = bus_rd & sel(bus_addr, ADDR_STATUS);
  wire rd_ctrl2  = bus_rd & sel(bus_addr, ADDR_CTRL2);
  wire rd_intreg = bus_rd & sel(bus_addr, ADDR_INT_REG);

  // Transmit queue state
  wire [7:0] txq_cnt   = wr_ptr_r - rd_ptr_r;
  wire       txq_empty = (txq_cnt == 8'h00);
  wire       txq_full  = (txq_cnt == TXQ_FULL_CNT);
  wire       push      = wr_txq & ~txq_full;
  wire       pop       = tx_fetch & ~txq_empty;
  wire       underrun  = tx_fetch & txq_empty;                      // RULE_13
  wire       tx_clr    = wr_ctrl2 & bus_wdata[C2_TX_CLR];

  wire [1:0] tx_fill =
    txq_empty                    ? TXF_EMPTY    :
    (txq_cnt >= tx_status_level) ? TXF_AT_LEVEL :
    (txq_cnt >= tx_irq_level)    ? TXF_AT_IRQ   : TXF_BELOW;       // RULE_05

  wire [1:0] rx_fill = rx_hold_r ? RXF_EMPTY : rx_fill_code;      // RULE_11

  // Interrupt bit 2 source selection
  wire bit2_evt = ctrl2_r[C2_INTSEL] ? underrun : rx_frame_abort; // RULE_06
  wire irq_evt  = hdlc_irq_event | (bit2_evt & bit2_mask);

  wire [7:0] status_word = {irq_raised_r, idle_r, rx_next_tag,
                            tx_fill, rx_fill};                     // RULE_04

  // Address compare, seven-bit mode ignores bit 0 but needs it set
  wire addr_hit = ctrl2_r[C2_SEVEN]
                ? (rx_addr_byte[7:1] == rx_addr_pattern[7:1])
                  & rx_addr_byte[0]
                : (rx_addr_byte == rx_addr_pattern);               // RULE_09

  wire [7:0] reload_val = ctrl2_r[C2_CYCLE]
                        ? byte_count_init - 8'h01
                        : byte_count_init;                         // RULE_07

  wire [7:0] rdata_nxt = rd_status ? status_word :
                         rd_ctrl2  ? ctrl2_r     : 8'h00;

  // Control register 2 next value
  always_comb begin
    ctrl2_nxt = ctrl2_r;
    if (wr_ctrl2) begin
      ctrl2_nxt = bus_wdata;                                       // RULE_15
    end else if (wr_txq) begin
      ctrl2_nxt[C2_TX_CLR] = 1'b0;                                 // RULE_12
    end
  end

  hsc_txmem u_txmem (
    .clk     (clk),
    .wr_en   (push),
    .wr_addr (wr_ptr_r[TXQ_AW-1:0]),
    .wr_data ({packet_end_tag, frame_abort_tag, bus_wdata}),
    .rd_en   (pop),
    .rd_addr (rd_ptr_r[TXQ_AW-1:0]),
    .rd_data (mem_q)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl2_r <= CTRL2_RESET;                                      // RULE_15
    end else begin
      ctrl2_r <= ctrl2_nxt;
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_raised_r <= 1'b0;
      bit2_r       <= 1'b0;
    end else begin
      irq_raised_r <= irq_evt | (irq_raised_r & ~rd_intreg);       // RULE_01
      bit2_r       <= bit2_evt | (bit2_r & ~rd_intreg);            // RULE_13
    end
  end

  // Idle channel detector
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ones_r <= 4'h0;
      idle_r <= IDLE_RESET;                                        // RULE_03
    end else if (rx_bit_valid) begin
      if (!rx_bit) begin
        ones_r <= 4'h0;
        idle_r <= 1'b0;                                            // RULE_03
      end else if (ones_r == IDLE_ONES - 4'h1 || ones_r == IDLE_ONES) begin
        ones_r <= IDLE_ONES;
        idle_r <= 1'b1;                                            // RULE_02
      end else begin
        ones_r <= ones_r + 4'h1;
      end
    end
  end

  // Receive hold and address match
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_hold_r    <= 1'b0;
      addr_match_r <= 1'b0;
    end else begin
      if (wr_ctrl2 && bus_wdata[C2_RX_CLR]) begin
        rx_hold_r <= 1'b1;                                         // RULE_11
      end else if (rx_flag_seen) begin
        rx_hold_r <= 1'b0;
      end
      if (rx_addr_valid) begin
        addr_match_r <= addr_hit;
      end
    end
  end

  // Queue pointers; a clear empties status but keeps contents
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= 8'h00;
      rd_ptr_r <= 8'h00;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 8'h01;
      end
      if (tx_clr) begin
        rd_ptr_r <= push ? wr_ptr_r + 8'h01 : wr_ptr_r;            // RULE_12
      end else if (pop) begin
        rd_ptr_r <= rd_ptr_r + 8'h01;
      end
    end
  end

  // Fetch pipeline and byte counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pop_r      <= 1'b0;
      fcs_ok_r   <= 1'b0;
      tx_count_r <= 8'h00;
    end else begin
      pop_r    <= pop;
      fcs_ok_r <= ~ctrl2_r[C2_CRC_OFF];                            // RULE_08
      if (tx_count_reload) begin
        tx_count_r <= reload_val;                                  // RULE_07
      end else if (pop && tx_count_r != 8'h00) begin
        tx_count_r <= tx_count_r - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r    <= 8'h00;
      rdata_oe_r <= 1'b0;
    end else begin
      rdata_oe_r <= rd_status | rd_ctrl2;
      if (bus_rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign bus_rdata     = rdata_r;
  assign bus_rdata_oe  = rdata_oe_r;
  assign int_bit2      = bit2_r;
  assign rx_hold       = rx_hold_r;
  assign addr_match    = addr_match_r;
  assign tag_clear     = push;                                     // RULE_14
  assign tx_byte_valid = pop_r;
  assign tx_byte       = mem_q[7:0];
  assign tx_byte_end   = mem_q[9];
  assign tx_byte_abort = mem_q[8];
  assign tx_send_fcs   = pop_r & mem_q[9] & fcs_ok_r;              // RULE_08
  assign tx_count      = tx_count_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  irq_flag_set_a: assert property (                                // RULE_01
    hdlc_irq_event |=> irq_raised_r)
    else $error("irq flag not set after event");
  irq_flag_clear_a: assert property (                              // RULE_01
    rd_intreg && !irq_evt |=> !irq_raised_r)
    else $error("irq flag not cleared by read");
  idle_set_a: assert property (                                    // RULE_02
    (rx_bit_valid && rx_bit && ones_r == 4'hE) |=> idle_r)
    else $error("idle not set after fifteen ones");
  idle_zero_a: assert property (                                   // RULE_03
    rx_bit_valid && !rx_bit |=> !idle_r && ones_r == 4'h0)
    else $error("idle not cleared by zero");
  rx_tag_read_a: assert property (                                 // RULE_04
    rd_status |=> bus_rdata[5:4] == $past(rx_next_tag) && bus_rdata_oe)
    else $error("status read lost receive tag");
  tx_fill_a: assert property (                                     // RULE_05
    rd_status && txq_cnt != 8'h00 && txq_cnt < tx_irq_level
      && txq_cnt < tx_status_level
      |=> bus_rdata[ST_TXF_HI:ST_TXF_LO] == TXF_BELOW)
    else $error("transmit fill code wrong");
  bit2_select_a: assert property (                                 // RULE_06
    ctrl2_r[C2_INTSEL] && tx_fetch && txq_empty |=> int_bit2)
    else $error("underrun not reported on bit 2");
  bit2_abort_a: assert property (                                  // RULE_06
    !ctrl2_r[C2_INTSEL] && rx_frame_abort |=> int_bit2)
    else $error("frame abort not reported on bit 2");
  count_cycle_a: assert property (                                 // RULE_07
    tx_count_reload && ctrl2_r[C2_CYCLE]
      |=> tx_count == $past(byte_count_init) - 8'h01)
    else $error("cycle reload value wrong");
  fcs_suppress_a: assert property (                                // RULE_08
    pop && ctrl2_r[C2_CRC_OFF] |=> !tx_send_fcs)
    else $error("checksum sent while suppressed");
  seven_bit_a: assert property (                                   // RULE_09
    rx_addr_valid && ctrl2_r[C2_SEVEN] && !rx_addr_byte[0]
      |=> !addr_match)
    else $error("seven-bit match without bit 0 set");
  rx_clear_a: assert property (                                    // RULE_11
    wr_ctrl2 && bus_wdata[C2_RX_CLR] && !rx_flag_seen
      |=> rx_hold && rx_fill == RXF_EMPTY)
    else $error("receive clear not applied");
  tx_clear_a: assert property (                                    // RULE_12
    tx_clr && !wr_txq |=> tx_fill == TXF_EMPTY ##1
      (ctrl2_r[C2_TX_CLR] || $past(wr_txq)))
    else $error("transmit clear not applied");
  tx_clr_auto_a: assert property (                                 // RULE_12
    wr_txq |=> !ctrl2_r[C2_TX_CLR])
    else $error("transmit clear did not self-clear");
  tag_clear_a: assert property (                                   // RULE_14
    push |-> tag_clear ##1 txq_cnt == $past(txq_cnt) + 8'h01
      - {7'h00, $past(pop)} || $past(tx_clr))
    else $error("tag not cleared on queue write");
  ctrl2_rw_a: assert property (                                    // RULE_15
    wr_ctrl2 ##1 !wr_ctrl2 ##1 rd_ctrl2
      |=> bus_rdata[7:1] == $past(bus_wdata[7:1], 3))
    else $error("control register readback wrong");
endmodule // hsc_channel

//--- inc/hsc_pkg.sv
package hsc_pkg;
  // Register map
  localparam logic [7:0] ADDR_TX_FIFO   = 8'h12;
  localparam logic [7:0] ADDR_STATUS    = 8'h13;
  localparam logic [7:0] ADDR_CTRL2     = 8'h14;
  localparam logic [7:0] ADDR_INT_REG   = 8'h16;

  // Status register fields
  localparam int ST_IRQ_BIT  = 7;
  localparam int ST_IDLE_BIT = 6;
  localparam int ST_RXTAG_HI = 5;
  localparam int ST_RXTAG_LO = 4;
  localparam int ST_TXF_HI   = 3;
  localparam int ST_TXF_LO   = 2;
  localparam int ST_RXF_HI   = 1;
  localparam int ST_RXF_LO   = 0;

  // Control register 2 fields
  localparam int C2_INTSEL   = 7;
  localparam int C2_CYCLE    = 6;
  localparam int C2_CRC_OFF  = 5;
  localparam int C2_SEVEN    = 4;
  localparam int C2_RX_CLR   = 1;
  localparam int C2_TX_CLR   = 0;
  localparam logic [7:0] CTRL2_RESET = 8'h00;

  // Idle channel detection
  localparam logic [3:0] IDLE_ONES  = 4'hF;
  localparam logic       IDLE_RESET = 1'b1;

  // Transmit queue
  localparam int TXQ_DEPTH = 128;
  localparam int TXQ_AW    = 7;
  localparam int TXQ_W     = 10;
  localparam logic [7:0] TXQ_FULL_CNT = 8'h80;

  // Transmit fill codes
  localparam logic [1:0] TXF_AT_LEVEL = 2'h0;
  localparam logic [1:0] TXF_AT_IRQ   = 2'h1;
  localparam logic [1:0] TXF_EMPTY    = 2'h2;
  localparam logic [1:0] TXF_BELOW    = 2'h3;

  // Receive fill code shown while the receive queue is cleared
  localparam logic [1:0] RXF_EMPTY    = 2'h0;
endpackage

//--- rtl/hsc_txmem.sv
`timescale 1ns/100ps
module hsc_txmem (
  input  wire logic                           clk,     // System clock
  input  wire logic                           wr_en,   // Write strobe
  input  wire logic [hsc_pkg::TXQ_AW-1:0]     wr_addr, // Write index
  input  wire logic [hsc_pkg::TXQ_W-1:0]      wr_data, // Tagged byte in
  input  wire logic                           rd_en,   // Read strobe
  input  wire logic [hsc_pkg::TXQ_AW-1:0]     rd_addr, // Read index
  output logic      [hsc_pkg::TXQ_W-1:0]      rd_data  // Registered out
);
  import hsc_pkg::*;

  logic [TXQ_W-1:0] mem [TXQ_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // hsc_txmem

//--- test/hsc_cpu_model.sv
`timescale 1ns/100ps
module hsc_cpu_model (
  input  wire logic       clk,       // System clock
  output logic      [7:0] bus_addr,  // Register address
  output logic            bus_rd,    // Read strobe
  output logic            bus_wr,    // Write strobe
  output logic      [7:0] bus_wdata, // Write data
  input  wire logic [7:0] bus_rdata  // Read data
);
  import hsc_pkg::*;
  initial begin
    bus_addr  = 8'h00;
    bus_rd    = 1'b0;
    bus_wr    = 1'b0;
    bus_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_addr  = a;
    bus_wdata = (a == ADDR_CTRL2) ? (d & 8'hF3) : d;
    bus_wr    = 1'b1;
    @(negedge clk);
    bus_wr    = 1'b0;
    bus_wdata = ~bus_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_rd   = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    d      = bus_rdata;
  endtask
endmodule // hsc_cpu_model

//--- test/test_hdlc_status_and_control2.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_hdlc_status_and_control2;
  import hsc_pkg::*;
  logic       clk = 0, reset_n = 0, bus_rd, bus_wr, bus_rdata_oe;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, rx_addr_byte, d;
  logic [7:0] rx_addr_pattern = 8'hA4, byte_count_init = 8'h0A;
  logic [7:0] tx_status_level = 8'h03, tx_irq_level = 8'h02;
  logic       hdlc_irq_event = 0, bit2_mask = 0, rx_frame_abort = 0;
  logic       rx_bit_valid = 0, rx_bit = 0, rx_flag_seen = 0;
  logic       rx_addr_valid = 0, packet_end_tag = 0, frame_abort_tag = 0;
  logic       tx_fetch = 0, tx_count_reload = 0;
  logic [1:0] rx_next_tag = 0, rx_fill_code = 2'h3;
  logic       int_bit2, rx_hold, addr_match, tag_clear, tx_byte_valid;
  logic       tx_byte_end, tx_byte_abort, tx_send_fcs;
  logic [7:0] tx_byte, tx_count;
  int         fails = 0, n_checks = 0, cyc = 0, n_tags = 0;

  hsc_cpu_model cpu (.clk, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
    .bus_rdata);
  hsc_channel uut (.clk, .reset_n, .bus_addr, .bus_rd, .bus_wr,
    .bus_wdata, .bus_rdata, .bus_rdata_oe, .hdlc_irq_event, .bit2_mask,
    .int_bit2, .rx_frame_abort, .rx_bit_valid, .rx_bit, .rx_next_tag,
    .rx_fill_code, .rx_flag_seen, .rx_hold, .rx_addr_valid, .rx_addr_byte,
    .rx_addr_pattern, .addr_match, .packet_end_tag, .frame_abort_tag,
    .tag_clear, .tx_status_level, .tx_irq_level, .tx_fetch, .tx_byte_valid,
    .tx_byte, .tx_byte_end, .tx_byte_abort, .tx_send_fcs, .byte_count_init,
    .tx_count_reload, .tx_count);

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results;
    end
  end

  // Counts accepted queue writes seen on tag_clear
  always @(posedge clk) begin
    if (tag_clear !== 1'b0) begin
      n_tags++;
    end
  end

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic bits(input logic v, input int n);
    repeat (n) begin
      @(negedge clk);
      rx_bit_valid = 1'b1;
      rx_bit       = v;
      @(negedge clk);
      rx_bit_valid = 1'b0;
      rx_bit       = ~v;
    end
    @(negedge clk);
  endtask
  task automatic stat(input logic [1:0] fill);
    cpu.rd(ADDR_STATUS, d);
    `CHK("tx_fill", fill, d[3:2])
  endtask
  task automatic fetch(input logic [7:0] b, input logic e, input logic f);
    pulse(tx_fetch);
    `CHK("valid", 1'b1, tx_byte_valid)
    `CHK("byte", b, tx_byte)
    `CHK("end", e, tx_byte_end)
    `CHK("fcs", f, tx_send_fcs)
  endtask

  task t_reset;
    cpu.rd(ADDR_CTRL2, d);
    `CHK("ctrl2", 8'h00, d)
    `CHK("oe", 1'b1, bus_rdata_oe)
    cpu.rd(ADDR_STATUS, d);
    `CHK("idle", 1'b1, d[ST_IDLE_BIT])
    `CHK("irq", 1'b0, d[ST_IRQ_BIT])
    `CHK("tx_fill", TXF_EMPTY, d[3:2])
    cpu.rd(8'h30, d);
    `CHK("oe_unmapped", 1'b0, bus_rdata_oe)
    cpu.wr(ADDR_CTRL2, 8'hF0);
    cpu.rd(ADDR_CTRL2, d);
    `CHK("ctrl2_rw", 8'hF0, d)
    cpu.wr(ADDR_CTRL2, 8'h00);
  endtask
  task t_idle;
    bits(1'b0, 1);
    cpu.rd(ADDR_STATUS, d);
    `CHK("idle0", 1'b0, d[ST_IDLE_BIT])
    bits(1'b1, 14);
    cpu.rd(ADDR_STATUS, d);
    `CHK("idle14", 1'b0, d[ST_IDLE_BIT])
    bits(1'b1, 1);
    cpu.rd(ADDR_STATUS, d);
    `CHK("idle15", 1'b1, d[ST_IDLE_BIT])
    for (int i = 0; i < 4; i++) begin
      rx_next_tag = 2'(i);
      cpu.rd(ADDR_STATUS, d);
      `CHK("rx_tag", 2'(i), d[5:4])
    end
  endtask
  task t_tx;
    cpu.wr(ADDR_TX_FIFO, 8'hA1);
    stat(TXF_BELOW);
    cpu.wr(ADDR_TX_FIFO, 8'hB2);
    stat(TXF_AT_IRQ);
    packet_end_tag = 1'b1;
    cpu.wr(ADDR_TX_FIFO, 8'hC3);
    packet_end_tag = 1'b0;
    stat(TXF_AT_LEVEL);
    fetch(8'hA1, 1'b0, 1'b0);
    fetch(8'hB2, 1'b0, 1'b0);
    fetch(8'hC3, 1'b1, 1'b1);
    `CHK("abort0", 1'b0, tx_byte_abort)
    stat(TXF_EMPTY);
    cpu.wr(ADDR_CTRL2, 8'h20);
    packet_end_tag = 1'b1;
    cpu.wr(ADDR_TX_FIFO, 8'h5E);
    packet_end_tag = 1'b0;
    fetch(8'h5E, 1'b1, 1'b0);
    `CHK("tag_clear", 4, n_tags)
  endtask
  task t_irq;
    pulse(tx_fetch);
    `CHK("no_underrun", 1'b0, int_bit2)
    cpu.wr(ADDR_CTRL2, 8'h80);
    pulse(tx_fetch);
    cpu.rd(ADDR_STATUS, d);
    `CHK("underrun", 1'b1, int_bit2)
    `CHK("masked", 1'b0, d[ST_IRQ_BIT])
    cpu.rd(ADDR_INT_REG, d);
    `CHK("int_clear", 1'b0, int_bit2)
    bit2_mask = 1'b1;
    pulse(tx_fetch);
    cpu.rd(ADDR_STATUS, d);
    `CHK("irq_set", 1'b1, d[ST_IRQ_BIT])
    cpu.rd(ADDR_INT_REG, d);
    cpu.rd(ADDR_STATUS, d);
    `CHK("irq_clr", 1'b0, d[ST_IRQ_BIT])
    cpu.wr(ADDR_CTRL2, 8'h00);
    pulse(rx_frame_abort);
    @(negedge clk);
    `CHK("abort", 1'b1, int_bit2)
    cpu.rd(ADDR_INT_REG, d);
    pulse(hdlc_irq_event);
    cpu.rd(ADDR_STATUS, d);
    `CHK("irq_ev", 1'b1, d[ST_IRQ_BIT])
    cpu.rd(ADDR_INT_REG, d);
  endtask
  task t_clear;
    cpu.wr(ADDR_TX_FIFO, 8'h11);
    cpu.wr(ADDR_TX_FIFO, 8'h22);
    cpu.wr(ADDR_CTRL2, 8'h03);
    stat(TXF_EMPTY);
    `CHK("rx_hold", 1'b1, rx_hold)
    `CHK("rx_fill", RXF_EMPTY, d[1:0])
    frame_abort_tag = 1'b1;
    cpu.wr(ADDR_TX_FIFO, 8'h33);
    frame_abort_tag = 1'b0;
    cpu.rd(ADDR_CTRL2, d);
    `CHK("txclr_self", 8'h02, d)
    stat(TXF_BELOW);
    fetch(8'h33, 1'b0, 1'b0);
    `CHK("abort1", 1'b1, tx_byte_abort)
    pulse(rx_flag_seen);
    `CHK("rx_run", 1'b0, rx_hold)
    cpu.wr(ADDR_CTRL2, 8'h10);
    rx_addr_byte = 8'hA5;
    pulse(rx_addr_valid);
    `CHK("seven_hit", 1'b1, addr_match)
    rx_addr_byte = 8'hA4;
    pulse(rx_addr_valid);
    `CHK("seven_b0", 1'b0, addr_match)
    cpu.wr(ADDR_CTRL2, 8'h40);
    pulse(tx_count_reload);
    `CHK("cycle", 8'h09, tx_count)
    cpu.wr(ADDR_CTRL2, 8'h00);
    pulse(rx_addr_valid);
    `CHK("eight_hit", 1'b1, addr_match)
  endtask

  task results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    rx_addr_byte = 8'h00;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    t_reset;
    t_idle;
    t_tx;
    t_irq;
    t_clear;
    results;
  end
endmodule // test_hdlc_status_and_control2
